//--- mfi_cpu_model.sv
// CPU sequencer model: takes requests, may return at once
`timescale 1ns/10ps
module mfi_cpu_model
   import mfi_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bench controls
   input wire logic ackOn,
   input wire logic [1:0] ackWait,
   input wire logic retiOn,
   // Sequencer side
   input wire logic intReq,
   output logic intAck,
   output logic returnFromInterrupt,
   output logic [MFI_PC_W-1:0] curPc
);
   logic [1:0] waitCnt;
   // Pc moves every cycle so a stale push shows up
   always @(posedge clk)
   begin
      curPc <= rst_b ? curPc + 13'h0005 : 13'h0000;
      returnFromInterrupt <= rst_b && intAck && intReq && retiOn;
      intAck <= 1'b0;
      if (!rst_b || !intReq || !ackOn || intAck)
         waitCnt <= 2'h0;
      else if (waitCnt == ackWait)
         intAck <= 1'b1;
      else
         waitCnt <= waitCnt + 2'h1;
   end
endmodule

//--- mfi_ctrl.sv
// Multi-function interrupt controller: source flags, groups, vectoring, wake-up
// Operation
// - Serial byte done sets serial flag
// - Serial vectors with global, source, group enables
// - Serial service clears global and group only
// - Pin falling edge sets pin flag
// - Pin request needs all enables, stack room
// - Pin service leaves pin flag set
// - EEPROM read/write end sets its flag
// - EEPROM vectors with all enables, stack room
// - EEPROM service leaves its flag set
// - Low supply sets flag; vectors when enabled
// - Low voltage service leaves its flag set
// - Timers give period, A, optional B flags
// - Timer flags set on comparator matches
// - Timer vectors when enabled; service clears group
// - Any flag rising wakes from sleep/idle
// - Set flag holds until service or clear
// - Only program counter is pushed
// - Interrupt return sets global; plain return not
// - Group flag set by member source flag
// - Six group flags, each with vector
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
module mfi_ctrl
   import mfi_pkg::*;
#(
   parameter int GROUPS = MFI_GROUPS,
   parameter int TIMERS = MFI_TIMERS,
   parameter int PC_W = MFI_PC_W,
   parameter int STACK_DEPTH = MFI_STACK_DEPTH,
   parameter logic [TIMERS-1:0] TIMER_HAS_B = 4'h8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   // Peripheral events
   input wire logic serialByteDone,
   input wire logic periphIntPin,
   input wire logic eepromCycleDone,
   input wire logic lowVoltDetect,
   input wire logic [TIMERS-1:0] timerPeriodMatch,
   input wire logic [TIMERS-1:0] timerMatchA,
   input wire logic [TIMERS-1:0] timerMatchB,
   // CPU sequencer
   input wire logic intAck,
   input wire logic [PC_W-1:0] curPc,
   input wire logic returnFromInterrupt,
   input wire logic plainReturn,
   input wire logic callPush,
   input wire logic sleepIdle,
   output logic intReq,
   output logic [2:0] intGroup,
   output logic [PC_W-1:0] retPc,
   output logic stackFull,
   output logic wakeUp
);
   localparam int NF = 4 + 3 * TIMERS;
   localparam int SW = $clog2(STACK_DEPTH + 1);
   localparam int AW = $clog2(STACK_DEPTH);

   // Group index is three bits and the flag word must fit one register
   if (GROUPS < 1 || GROUPS > MFI_GROUPS || NF > 16 || TIMERS < 1)
   begin : gBadSize
      $error("mfi_ctrl: unsupported parameters");
   end
   // Stack slots are addressed by pointer bits, so the depth is a power of two
   if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
   begin : gBadDepth
      $error("mfi_ctrl: stack depth must be a power of two");
   end

   // Pin synchroniser: three stages, change counts when the last two agree
   logic [2:0] pinSync_ff;
   logic pinLevel_ff;
   logic pinFall;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pinSync_ff <= 3'h7;
         pinLevel_ff <= 1'b1;
      end
      else
      begin
         pinSync_ff <= {pinSync_ff[1:0], periphIntPin};
         if (pinSync_ff[2] == pinSync_ff[1])
            pinLevel_ff <= pinSync_ff[1];
      end
   end
   // Only the high-to-low change is an event
   assign pinFall = pinLevel_ff & (pinSync_ff[2] == pinSync_ff[1]) & ~pinSync_ff[1];

   // Source set events
   // Level inputs: every high cycle is a new set event
   logic [NF-1:0] srcSet;
   always_comb
   begin
      srcSet = '0;
      srcSet[MFI_BIT_SERIAL] = serialByteDone;
      srcSet[MFI_BIT_PIN] = pinFall;
      srcSet[MFI_BIT_EEPROM] = eepromCycleDone;
      srcSet[MFI_BIT_LOWVOLT] = lowVoltDetect;
      for (int t = 0; t < TIMERS; t++)
      begin
         // Period, A and, on enhanced timers, B match flags
         srcSet[MFI_BIT_TIMER0 + 3*t] = timerPeriodMatch[t];
         srcSet[MFI_BIT_TIMER0 + 3*t + 1] = timerMatchA[t];
         srcSet[MFI_BIT_TIMER0 + 3*t + 2] = timerMatchB[t] & TIMER_HAS_B[t];
      end
   end

   // Register decode
   wire wrGlobal = regWr && regAddr == MFI_REG_GLOBAL;
   wire wrSrcFlag = regWr && regAddr == MFI_REG_SRC_FLAG;
   wire wrSrcEn = regWr && regAddr == MFI_REG_SRC_EN;
   wire wrGrpFlag = regWr && regAddr == MFI_REG_GRP_FLAG;
   wire wrGrpEn = regWr && regAddr == MFI_REG_GRP_EN;
   wire wrMap0 = regWr && regAddr == MFI_REG_SRC_MAP0;
   wire wrMap1 = regWr && regAddr == MFI_REG_SRC_MAP1;
   wire wrMap2 = regWr && regAddr == MFI_REG_SRC_MAP2;

   // Source flags: hardware never clears them
   // Software writes the whole word; a set event in that cycle still wins
   logic [NF-1:0] srcFlag;
   logic [NF-1:0] srcRise;
   genvar g;
   generate
      for (g = 0; g < NF; g++)
      begin : gSrc
         mfi_flag uFlag
         (
            .clk(clk),
            .rst_b(rst_b),
            .setEvt(srcSet[g]),
            .swWrite(wrSrcFlag),
            .swData(regWrData[g]),
            .flag(srcFlag[g]),
            .rise(srcRise[g])
         );
      end
   endgenerate

   // Enables and group map
   logic [NF-1:0] srcEn_ff;
   logic [GROUPS-1:0] grpEn_ff;
   // Three bits per source; bits above the last source are spare
   logic [47:0] map_ff;
   logic [NF-1:0] srcSeen_ff;
   logic gie_ff;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         srcEn_ff <= '0;
         grpEn_ff <= '0;
         map_ff <= MFI_RST_MAP;
      end
      else
      begin
         if (wrSrcEn)
            srcEn_ff <= regWrData[NF-1:0];
         if (wrGrpEn)
            grpEn_ff <= regWrData[GROUPS-1:0];
         if (wrMap0)
            map_ff[15:0] <= regWrData;
         if (wrMap1)
            map_ff[31:16] <= regWrData;
         if (wrMap2)
            map_ff[47:32] <= regWrData;
      end
   end

   // A source already set when enabled counts once; a fresh rise counts again
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         srcSeen_ff <= '0;
      else
         srcSeen_ff <= srcEn_ff & (srcFlag | srcRise);
   end

   // Enabled source rising into its group
   logic [GROUPS-1:0] grpSet;
   always_comb
   begin
      grpSet = '0;
      for (int s = 0; s < NF; s++)
      begin
         for (int k = 0; k < GROUPS; k++)
         begin
            if (map_ff[3*s +: 3] == 3'(k) && srcEn_ff[s] && (srcRise[s] || (srcFlag[s] && !srcSeen_ff[s])))
               grpSet[k] = 1'b1;
         end
      end
   end

   // Group flags; service and software clear them, source flags stay
   logic [GROUPS-1:0] grpFlag_ff;
   logic [GROUPS-1:0] grpClr;

   // Vectoring: lowest pending enabled group wins
   logic [GROUPS-1:0] grpPend;
   logic [2:0] winGroup;
   logic anyPend;
   logic [SW-1:0] sp_ff;
   assign stackFull = (sp_ff == SW'(STACK_DEPTH));
   // Disabled groups keep their flags but never request
   assign grpPend = grpFlag_ff & grpEn_ff;
   always_comb
   begin
      winGroup = '0;
      anyPend = 1'b0;
      for (int k = GROUPS - 1; k >= 0; k--)
      begin
         if (grpPend[k])
         begin
            winGroup = 3'(k);
            anyPend = 1'b1;
         end
      end
   end
   // A full stack holds the request back; the group flag stays pending
   assign intReq = anyPend & gie_ff & ~stackFull;
   assign intGroup = winGroup;
   // Service is the edge that sees request and acknowledge together
   wire take = intReq & intAck;

   always_comb
   begin
      grpClr = '0;
      if (take)
         grpClr[winGroup] = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         grpFlag_ff <= MFI_RST_GRP[GROUPS-1:0];
      end
      else
      begin
         // Set wins over service clear and software clear
         grpFlag_ff <= grpSet | (grpFlag_ff & ~grpClr & ~(wrGrpFlag ? ~regWrData[GROUPS-1:0] : '0));
      end
   end

   // Global enable: cleared on service, set by interrupt return or by a register write
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         gie_ff <= MFI_RST_GIE;
      else if (take)
         gie_ff <= 1'b0;
      else if (returnFromInterrupt)
         gie_ff <= 1'b1;
      else if (wrGlobal)
         gie_ff <= regWrData[0];
   end

   // Return stack holds program counters only
   // No reset on the slots; only the pointer says what is valid
   logic [PC_W-1:0] stack_ff [STACK_DEPTH];
   wire doPush = take | (callPush & ~stackFull);
   // A return beside a push is dropped; the sequencer never issues both
   wire doPop = (returnFromInterrupt | plainReturn) & (sp_ff != '0) & ~doPush;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         sp_ff <= '0;
      else if (doPush)
         sp_ff <= sp_ff + SW'(1);
      else if (doPop)
         sp_ff <= sp_ff - SW'(1);
   end
   always_ff @(posedge clk)
   begin
      if (doPush)
         stack_ff[sp_ff[AW-1:0]] <= curPc;
   end
   // Popped counter stands until the next pop
   logic [PC_W-1:0] retPc_ff;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         retPc_ff <= '0;
      else if (doPop)
         retPc_ff <= stack_ff[AW'(sp_ff - SW'(1))];
   end
   assign retPc = retPc_ff;

   // Wake-up ignores every enable; works from flag transitions alone
   logic wake_ff;
   // A software set counts as a rise too, so presetting must precede sleep
   wire anyRise = |srcRise;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         wake_ff <= 1'b0;
      else if (!sleepIdle)
         wake_ff <= 1'b0;
      else if (anyRise)
         wake_ff <= 1'b1;
   end
   assign wakeUp = wake_ff | (sleepIdle & anyRise);

   // Read port, data one cycle after the strobe
   // Unmapped offsets and spare bits read as zero
   logic [15:0] rdMux;
   always_comb
   begin
      rdMux = '0;
      unique case (regAddr)
         MFI_REG_GLOBAL: rdMux[0] = gie_ff;
         MFI_REG_SRC_FLAG: rdMux[NF-1:0] = srcFlag;
         MFI_REG_SRC_EN: rdMux[NF-1:0] = srcEn_ff;
         MFI_REG_GRP_FLAG: rdMux[GROUPS-1:0] = grpFlag_ff;
         MFI_REG_GRP_EN: rdMux[GROUPS-1:0] = grpEn_ff;
         MFI_REG_SRC_MAP0: rdMux = map_ff[15:0];
         MFI_REG_SRC_MAP1: rdMux = map_ff[31:16];
         MFI_REG_SRC_MAP2: rdMux = map_ff[47:32];
         MFI_REG_STATUS: rdMux[1:0] = {wake_ff, stackFull};
         default: rdMux = '0;
      endcase
   end
   logic [15:0] rdData_ff;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rdData_ff <= '0;
      else if (regRd)
         rdData_ff <= rdMux;
      // Bus expects zero outside the answer cycle
      else
         rdData_ff <= '0;
   end
   assign regRdData = rdData_ff;
endmodule

//--- mfi_ctrl_props.sv
// Port assertions for the interrupt controller
`timescale 1ns/10ps
module mfi_ctrl_chk
#(
   parameter int GROUPS = 6,
   parameter int PC_W = 13
)
(
   // Clock, reset, register port
   input wire logic clk,
   input wire logic rst_b,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdData,
   // Sequencer side
   input wire logic intAck,
   input wire logic [PC_W-1:0] curPc,
   input wire logic returnFromInterrupt,
   input wire logic plainReturn,
   input wire logic callPush,
   input wire logic sleepIdle,
   input wire logic intReq,
   input wire logic [2:0] intGroup,
   input wire logic [PC_W-1:0] retPc,
   input wire logic stackFull,
   input wire logic wakeUp
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence sTake;
      intReq && intAck && !regWr && !returnFromInterrupt && !callPush && !plainReturn;
   endsequence
   sequence sPop;
      returnFromInterrupt && !intAck && !callPush && !plainReturn;
   endsequence
   take_drop_a: assert property (sTake |=> !intReq) else $error("req after take");
   ret_pc_a: assert property (sTake ##1 sPop |=> retPc == $past(curPc, 2)) else $error("bad pc");
   stack_block_a: assert property (stackFull |-> !intReq) else $error("req on full stack");
   group_range_a: assert property (intReq |-> intGroup < GROUPS) else $error("bad group");
   req_hold_a: assert property (intReq && !intAck && !regWr && !callPush && !plainReturn && !returnFromInterrupt
      |=> intReq && intGroup <= $past(intGroup)) else $error("req lost");
   wake_idle_a: assert property (!sleepIdle && !$past(sleepIdle) |-> !wakeUp) else $error("wake awake");
   idle_rd_a: assert property (!regRd |=> regRdData == 16'h0000) else $error("stray read data");
   full_cause_a: assert property ($rose(stackFull) |-> $past(callPush) || $past(intAck)) else $error("full");
endmodule
bind mfi_ctrl mfi_ctrl_chk #(.GROUPS(GROUPS), .PC_W(PC_W)) mfi_ctrl_chk_inst (.clk(clk), .rst_b(rst_b),
   .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .intAck(intAck), .curPc(curPc),
   .returnFromInterrupt(returnFromInterrupt), .plainReturn(plainReturn), .callPush(callPush),
   .sleepIdle(sleepIdle), .intReq(intReq), .intGroup(intGroup), .retPc(retPc), .stackFull(stackFull),
   .wakeUp(wakeUp));

//--- mfi_flag.sv
// One sticky request flag with hardware set and software clear
`timescale 1ns/10ps
module mfi_flag
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Controls
   input wire logic setEvt,
   input wire logic swWrite,
   input wire logic swData,
   // State
   output logic flag,
   output logic rise
);
   logic flag_ff;
   logic nxt_flag;

   // Hardware set beats a software clear in the same cycle
   assign nxt_flag = setEvt | (swWrite ? swData : flag_ff);
   assign flag = flag_ff;
   assign rise = nxt_flag & ~flag_ff;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         flag_ff <= 1'b0;
      else
         flag_ff <= nxt_flag;
   end
endmodule

//--- mfi_pkg.sv
// Package of constants for the multi-function interrupt block
package mfi_pkg;
   localparam int MFI_GROUPS = 6;
   localparam int MFI_TIMERS = 4;
   localparam int MFI_FLAGS = 4 + 3 * MFI_TIMERS;
   localparam int MFI_PC_W = 13;
   localparam int MFI_STACK_DEPTH = 8;

   // Register offsets
   localparam logic [3:0] MFI_REG_GLOBAL = 4'h0;
   localparam logic [3:0] MFI_REG_SRC_FLAG = 4'h1;
   localparam logic [3:0] MFI_REG_SRC_EN = 4'h2;
   localparam logic [3:0] MFI_REG_GRP_FLAG = 4'h3;
   localparam logic [3:0] MFI_REG_GRP_EN = 4'h4;
   localparam logic [3:0] MFI_REG_SRC_MAP0 = 4'h5;
   localparam logic [3:0] MFI_REG_SRC_MAP1 = 4'h6;
   localparam logic [3:0] MFI_REG_SRC_MAP2 = 4'h8;
   localparam logic [3:0] MFI_REG_STATUS = 4'h7;

   // Source flag positions
   localparam int MFI_BIT_SERIAL = 0;
   localparam int MFI_BIT_PIN = 1;
   localparam int MFI_BIT_EEPROM = 2;
   localparam int MFI_BIT_LOWVOLT = 3;
   localparam int MFI_BIT_TIMER0 = 4;

   // Status register positions
   localparam int MFI_BIT_STK_FULL = 0;
   localparam int MFI_BIT_WAKE = 1;

   // Reset values
   localparam logic MFI_RST_GIE = 1'b0;
   localparam logic [MFI_FLAGS-1:0] MFI_RST_SRC = '0;
   localparam logic [MFI_GROUPS-1:0] MFI_RST_GRP = '0;
   // Default source-to-group map: 3 bits per source
   localparam logic [3*MFI_FLAGS-1:0] MFI_RST_MAP = 48'h5b6_d924_9200;
endpackage

//--- tb_mfi_ctrl.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module tb_mfi_ctrl
   import mfi_pkg::*;
();
   localparam logic [3:0] HAS_B = 4'h8;
   logic clk = 1'b0, rst_b = 1'b0, we = 1'b0, re = 1'b0, ser = 1'b0, pin = 1'b1, eep = 1'b0, lv = 1'b0;
   logic ret = 1'b0, push = 1'b0, slp = 1'b0, ackOn = 1'b0, retiOn = 1'b0, ack, rfi, req, full, wake;
   logic [1:0] ackWait = 2'h0;
   logic [2:0] grp;
   logic [3:0] addr = 4'h0, tP = 4'h0, tA = 4'h0, tB = 4'h0;
   logic [7:0] rnd = 8'h29;
   logic [15:0] wd = 16'h0000, rdd;
   logic [MFI_PC_W-1:0] pc, rpc, savedPc;
   int errTotal = 0, nCompared = 0, cyc = 0, mSrc = 0;
   mfi_ctrl #(.TIMER_HAS_B(HAS_B)) mfi_ctrl_inst (.clk(clk), .rst_b(rst_b), .regAddr(addr), .regWrData(wd),
      .regWr(we), .regRd(re), .regRdData(rdd), .serialByteDone(ser), .periphIntPin(pin), .eepromCycleDone(eep),
      .lowVoltDetect(lv), .timerPeriodMatch(tP), .timerMatchA(tA), .timerMatchB(tB), .intAck(ack), .curPc(pc),
      .returnFromInterrupt(rfi), .plainReturn(ret), .callPush(push), .sleepIdle(slp), .intReq(req),
      .intGroup(grp), .retPc(rpc), .stackFull(full), .wakeUp(wake));
   mfi_cpu_model mfi_cpu_model_inst (.clk(clk), .rst_b(rst_b), .ackOn(ackOn), .ackWait(ackWait),
      .retiOn(retiOn), .intReq(req), .intAck(ack), .returnFromInterrupt(rfi), .curPc(pc));
   always #2 clk = ~clk;
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic printVerdict();
      if (errTotal == 0 && nCompared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errTotal++;
         $display("CHECK FAILED %0t timeout", $time);
         printVerdict();
      end
   end
   function automatic logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic wr(logic [3:0] a, logic [15:0] d);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [3:0] a, logic [15:0] e);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 chk(rdd, e);
      @(posedge clk);
   endtask
   // One-cycle events; the model ORs them into the expected flags
   task automatic evt(logic [2:0] s, logic [11:0] t);
      {lv, eep, ser} <= s;
      {tB, tA, tP} <= t;
      mSrc |= s[0] | (s[1] << 2) | (s[2] << 3);
      for (int i = 0; i < 4; i++)
         mSrc |= (t[i] << (4 + 3 * i)) | (t[4 + i] << (5 + 3 * i)) | ((t[8 + i] & HAS_B[i]) << (6 + 3 * i));
      @(posedge clk);
      {lv, eep, ser} <= 3'h0;
      {tB, tA, tP} <= 12'h000;
      @(posedge clk);
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 16; a++)
         case (4'(a))
            MFI_REG_SRC_MAP0: rd(4'(a), MFI_RST_MAP[15:0]);
            MFI_REG_SRC_MAP1: rd(4'(a), MFI_RST_MAP[31:16]);
            MFI_REG_SRC_MAP2: rd(4'(a), MFI_RST_MAP[47:32]);
            default: rd(4'(a), 16'h0000);
         endcase
      rnd = lfsr(rnd);
      wr(MFI_REG_SRC_MAP2, {rnd, ~rnd});
      rd(MFI_REG_SRC_MAP2, {rnd, ~rnd});
      for (int i = 0; i < 6; i++)
      begin
         rnd = lfsr(rnd);
         evt(i == 5 ? 3'h7 : rnd[2:0], {rnd, rnd[7:4]});
         rd(MFI_REG_SRC_FLAG, mSrc[15:0]);
      end
      rd(MFI_REG_GRP_FLAG, 16'h0000);
      wr(MFI_REG_SRC_FLAG, 16'h0000);
      ser <= 1'b1;
      fork
         wr(MFI_REG_SRC_FLAG, 16'h0000);
         begin
            @(posedge clk);
            ser <= 1'b0;
         end
      join
      rd(MFI_REG_SRC_FLAG, 16'h0001);
      wr(MFI_REG_SRC_FLAG, 16'h0000);
      pin <= 1'b0;
      repeat (6) @(posedge clk);
      rd(MFI_REG_SRC_FLAG, 16'h0002);
      wr(MFI_REG_SRC_FLAG, 16'h0000);
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd(MFI_REG_SRC_FLAG, 16'h0000);
      wr(MFI_REG_SRC_EN, 16'h0001);
      wr(MFI_REG_GRP_EN, 16'h0001);
      evt(3'h1, 12'h000);
      rd(MFI_REG_GRP_FLAG, 16'h0001);
      wr(MFI_REG_GLOBAL, 16'h0001);
      retiOn <= 1'b1;
      ackOn <= 1'b1;
      repeat (5) @(posedge clk);
      ackOn <= 1'b0;
      rd(MFI_REG_GLOBAL, 16'h0001);
      rd(MFI_REG_GRP_FLAG, 16'h0000);
      rd(MFI_REG_SRC_FLAG, 16'h0001);
      retiOn <= 1'b0;
      ackWait <= 2'h3;
      wr(MFI_REG_SRC_FLAG, 16'h0000);
      ackOn <= 1'b1;
      evt(3'h1, 12'h000);
      repeat (8) @(posedge clk);
      ackOn <= 1'b0;
      rd(MFI_REG_GLOBAL, 16'h0000);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      rd(MFI_REG_GLOBAL, 16'h0000);
      wr(MFI_REG_SRC_EN, 16'h0000);
      wr(MFI_REG_SRC_FLAG, 16'h0000);
      slp <= 1'b1;
      evt(3'h2, 12'h000);
      #1 chk(16'(wake), 16'h0001);
      @(posedge clk);
      slp <= 1'b0;
      wr(MFI_REG_SRC_FLAG, 16'hffff);
      slp <= 1'b1;
      evt(3'h7, 12'hfff);
      #1 chk(16'(wake), 16'h0000);
      @(posedge clk);
      slp <= 1'b0;
      wr(MFI_REG_GLOBAL, 16'h0001);
      wr(MFI_REG_SRC_EN, 16'h0001);
      push <= 1'b1;
      repeat (8) @(posedge clk);
      push <= 1'b0;
      savedPc = pc;
      rd(MFI_REG_STATUS, 16'h0001);
      #1 chk(16'({full, req}), 16'h0002);
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      #1 chk(16'(req), 16'h0001);
      chk(16'(grp), 16'h0000);
      chk(16'(rpc), 16'(savedPc));
      @(posedge clk);
      wr(MFI_REG_GRP_FLAG, 16'h0000);
      #1 chk(16'(req), 16'h0000);
      printVerdict();
   end
endmodule
